// ==== error_indicator_pkg.sv ====
package error_indicator_pkg;

  // Lamp drive patterns.
  typedef enum logic [2:0] {
    PAT_OFF,
    PAT_ON,
    PAT_FLICKER,
    PAT_BLINK,
    PAT_SINGLE_FLASH,
    PAT_DOUBLE_FLASH
  } lamp_pattern_e;

  // Seven-segment character codes, seg[6:0] = g f e d c b a, active high.
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_E = 7'h79;
  localparam logic [6:0] SEG_R = 7'h50;
  localparam logic [6:0] SEG_D = 7'h5E;
  localparam logic [6:0] SEG_H = 7'h76;
  localparam logic [6:0] SEG_B = 7'h7C;
  localparam logic [6:0] SEG_Y = 7'h6E;
  localparam logic [6:0] SEG_1 = 7'h06;
  localparam logic [6:0] SEG_3 = 7'h4F;
  localparam logic [6:0] SEG_4 = 7'h66;
  localparam logic [6:0] SEG_7 = 7'h07;

  // Hex digit table for node address or axis number.
  localparam logic [6:0] HEX_SEG [16] = '{
    7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
    7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71
  };

  // Display phase and pattern timing.
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned PHASE_MS = 500;
  localparam int unsigned PHASE_CYCLES = CLK_HZ / 1000 * PHASE_MS;
  localparam int unsigned FLICKER_MS = 50;
  localparam int unsigned FLICKER_CYCLES = CLK_HZ / 1000 * FLICKER_MS;

  // Minimum host revision for synchronous control, as major and minor.
  localparam logic [3:0] REV_MIN_MAJOR = 4'h1;
  localparam logic [3:0] REV_MIN_MINOR = 4'h3;

endpackage

// ==== lamp_pattern_gen.sv ====
`timescale 1ns/1ps
// Turns a pattern code into a lamp level using its own tick divider.
module lamp_pattern_gen #(
  parameter int unsigned TICK_CYCLES = 6250000
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] pattern_i,
  output logic lamp_o
);

  logic [31:0] tick_cnt;
  logic tick;
  logic [3:0] step;

  // Free running tick divider.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end
    else if (tick_cnt >= TICK_CYCLES - 1)
    begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // Sixteen-step pattern sequencer.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      step <= 4'h0;
    else if (tick)
      step <= step + 4'h1;
  end

  // Lamp level per pattern; flash patterns use a long dark gap.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      lamp_o <= 1'b0;
    else
    begin
      case (pattern_i)
        3'(error_indicator_pkg::PAT_ON): lamp_o <= 1'b1;
        3'(error_indicator_pkg::PAT_FLICKER): lamp_o <= step[0];
        3'(error_indicator_pkg::PAT_BLINK): lamp_o <= step[2];
        3'(error_indicator_pkg::PAT_SINGLE_FLASH): lamp_o <= (step[3:1] == 3'h0);
        3'(error_indicator_pkg::PAT_DOUBLE_FLASH):
          lamp_o <= (step[3:1] == 3'h0) || (step[3:1] == 3'h2);
        default: lamp_o <= 1'b0;
      endcase
    end
  end

endmodule

// ==== error_indicator_encoder.sv ====
`timescale 1ns/1ps
module error_indicator_encoder #(
  parameter int unsigned NODE_COUNT = 16,
  parameter int unsigned PHASE_CYCLES = error_indicator_pkg::PHASE_CYCLES,
  parameter int unsigned TICK_CYCLES = error_indicator_pkg::FLICKER_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic host_power_fail_i,
  input wire logic system_fault_i,
  input wire logic unit_number_bad_i,
  input wire logic host_init_fail_i,
  input wire logic unit_not_registered_i,
  input wire logic [7:0] host_revision_i,
  input wire logic sync_control_req_i,
  input wire logic program_memory_fault_i,
  input wire logic [NODE_COUNT-1:0] slave_al_error_i,
  input wire logic sync_link_enable_i,
  input wire logic [2:0] run_pattern_i,
  output logic run_lamp_o,
  output logic unit_fault_lamp_o,
  output logic host_fault_lamp_o,
  output logic [6:0] seg_left_o,
  output logic [6:0] seg_right_o,
  output logic dp_left_o,
  output logic outputs_off_o
);

  typedef enum logic [1:0] {
    SHOW_MARK,
    SHOW_CODE,
    SHOW_NODE
  } show_state_e;

  // Two-flop synchronisers for all pin inputs.
  localparam int unsigned SYNC_W = 8 + 8 + NODE_COUNT + 1;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [7:0] rev_a;
  logic [7:0] rev_b;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync_a <= '0;
      sync_b <= '0;
      rev_a <= '0;
      rev_b <= '0;
    end
    else
    begin
      sync_a <= {host_power_fail_i, system_fault_i, unit_number_bad_i, host_init_fail_i,
                 unit_not_registered_i, sync_control_req_i, program_memory_fault_i, 1'b0,
                 run_pattern_i, 5'h00, slave_al_error_i, sync_link_enable_i};
      sync_b <= sync_a;
      rev_a <= host_revision_i;
      rev_b <= rev_a;
    end
  end

  logic s_pwr, s_sys, s_unum, s_init, s_unreg, s_sreq, s_pmem;
  logic [2:0] s_runpat;
  logic [NODE_COUNT-1:0] s_al;
  logic s_link;
  assign {s_pwr, s_sys, s_unum, s_init, s_unreg, s_sreq, s_pmem} = sync_b[SYNC_W-1 -: 7];
  assign s_runpat = sync_b[SYNC_W-9 -: 3];
  assign s_al = sync_b[NODE_COUNT:1];
  assign s_link = sync_b[0];

  // Host revision below minimum when major/minor compare low.
  logic rev_old;
  assign rev_old = (rev_b[7:4] < error_indicator_pkg::REV_MIN_MAJOR) ||
                   ((rev_b[7:4] == error_indicator_pkg::REV_MIN_MAJOR) &&
                    (rev_b[3:0] < error_indicator_pkg::REV_MIN_MINOR));

  // Sticky error latches; only reset clears them.
  logic l_pwr, l_sys, l_unum, l_init, l_unreg, l_rev, l_pmem;
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      l_pwr <= 1'b0;
      l_sys <= 1'b0;
      l_unum <= 1'b0;
      l_init <= 1'b0;
      l_unreg <= 1'b0;
      l_rev <= 1'b0;
      l_pmem <= 1'b0;
    end
    else
    begin
      l_pwr <= l_pwr | s_pwr;
      l_sys <= l_sys | s_sys;
      l_unum <= l_unum | s_unum;
      l_init <= l_init | s_init;
      l_unreg <= l_unreg | s_unreg;
      l_rev <= l_rev | (s_sreq & rev_old);
      l_pmem <= l_pmem | s_pmem;
    end
  end

  logic dark;
  logic host_err;
  logic any_al;
  assign dark = l_pwr | l_sys;
  assign host_err = l_unum | l_init | l_unreg | l_rev;
  assign any_al = |s_al;

  // Lamp pattern selection in order of severity.
  logic [2:0] run_pat;
  logic [2:0] ucf_pat;
  logic [2:0] hst_pat;
  always_comb
  begin
    run_pat = s_runpat;
    ucf_pat = 3'(error_indicator_pkg::PAT_OFF);
    hst_pat = 3'(error_indicator_pkg::PAT_OFF);
    if (dark)
      run_pat = 3'(error_indicator_pkg::PAT_OFF);
    else if (host_err)
    begin
      run_pat = 3'(error_indicator_pkg::PAT_OFF);
      hst_pat = 3'(error_indicator_pkg::PAT_ON);
    end
    else if (l_pmem)
    begin
      run_pat = 3'(error_indicator_pkg::PAT_OFF);
      ucf_pat = 3'(error_indicator_pkg::PAT_ON);
    end
  end

  lamp_pattern_gen #(.TICK_CYCLES(TICK_CYCLES)) u_run (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pattern_i(run_pat), .lamp_o(run_lamp_o)
  );
  lamp_pattern_gen #(.TICK_CYCLES(TICK_CYCLES)) u_ucf (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pattern_i(ucf_pat), .lamp_o(unit_fault_lamp_o)
  );
  lamp_pattern_gen #(.TICK_CYCLES(TICK_CYCLES)) u_hst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pattern_i(hst_pat), .lamp_o(host_fault_lamp_o)
  );

  // Output cut-off on system fault.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      outputs_off_o <= 1'b0;
    else
      outputs_off_o <= l_sys;
  end

  // Display phase timer.
  logic [31:0] phase_cnt;
  logic phase_tick;
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      phase_cnt <= '0;
      phase_tick <= 1'b0;
    end
    else if (phase_cnt >= PHASE_CYCLES - 1)
    begin
      phase_cnt <= '0;
      phase_tick <= 1'b1;
    end
    else
    begin
      phase_cnt <= phase_cnt + 32'h1;
      phase_tick <= 1'b0;
    end
  end

  // Next affected node at or after a start index, wrapping to the first.
  localparam int unsigned NW = $clog2(NODE_COUNT);
  function automatic logic [NW-1:0] next_node(input logic [NODE_COUNT-1:0] al,
                                               input logic [NW-1:0] from);
    logic [NW-1:0] r;
    r = '0;
    for (int i = NODE_COUNT - 1; i >= 0; i--)
    begin
      if (al[i])
        r = NW'(i);
    end
    for (int i = NODE_COUNT - 1; i >= 0; i--)
    begin
      if (al[i] && (NW'(i) >= from))
      begin
        r = NW'(i);
      end
    end
    return r;
  endfunction

  // Er / code / node sequencer walking through affected nodes.
  show_state_e show_state;
  logic [NW-1:0] node_idx;
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      show_state <= SHOW_MARK;
      node_idx <= '0;
    end
    else if (!any_al)
    begin
      show_state <= SHOW_MARK;
      node_idx <= '0;
    end
    else if (phase_tick)
    begin
      case (show_state)
        SHOW_MARK: show_state <= SHOW_CODE;
        SHOW_CODE:
        begin
          show_state <= SHOW_NODE;
          node_idx <= next_node(s_al, node_idx);
        end
        SHOW_NODE:
        begin
          show_state <= SHOW_MARK;
          node_idx <= node_idx + NW'(1);
        end
        default: show_state <= SHOW_MARK;
      endcase
    end
  end

  // Character selection; host and memory codes override node display.
  logic [6:0] next_left;
  logic [6:0] next_right;
  logic [7:0] node_num;
  always_comb
  begin
    node_num = 8'(node_idx);
    next_left = error_indicator_pkg::SEG_BLANK;
    next_right = error_indicator_pkg::SEG_BLANK;
    if (dark)
    begin
      next_left = error_indicator_pkg::SEG_BLANK;
      next_right = error_indicator_pkg::SEG_BLANK;
    end
    else if (l_unum)
    begin
      next_left = error_indicator_pkg::SEG_H;
      next_right = error_indicator_pkg::SEG_1;
    end
    else if (l_init)
    begin
      next_left = error_indicator_pkg::SEG_H;
      next_right = error_indicator_pkg::SEG_B;
    end
    else if (l_unreg)
    begin
      next_left = error_indicator_pkg::SEG_H;
      next_right = error_indicator_pkg::SEG_7;
    end
    else if (l_rev)
    begin
      next_left = error_indicator_pkg::SEG_Y;
      next_right = error_indicator_pkg::SEG_4;
    end
    else if (l_pmem)
    begin
      next_left = error_indicator_pkg::SEG_H;
      next_right = error_indicator_pkg::SEG_3;
    end
    else if (any_al)
    begin
      case (show_state)
        SHOW_MARK:
        begin
          next_left = error_indicator_pkg::SEG_E;
          next_right = error_indicator_pkg::SEG_R;
        end
        SHOW_CODE:
        begin
          next_left = error_indicator_pkg::SEG_D;
          next_right = error_indicator_pkg::SEG_D;
        end
        SHOW_NODE:
        begin
          next_left = error_indicator_pkg::HEX_SEG[node_num[7:4]];
          next_right = error_indicator_pkg::HEX_SEG[node_num[3:0]];
        end
        default:
        begin
          next_left = error_indicator_pkg::SEG_BLANK;
          next_right = error_indicator_pkg::SEG_BLANK;
        end
      endcase
    end
  end

  // Registered display drive; decimal point flashes with the phase timer.
  logic dp_phase;
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      seg_left_o <= error_indicator_pkg::SEG_BLANK;
      seg_right_o <= error_indicator_pkg::SEG_BLANK;
      dp_left_o <= 1'b0;
      dp_phase <= 1'b0;
    end
    else
    begin
      seg_left_o <= next_left;
      seg_right_o <= next_right;
      if (phase_tick)
        dp_phase <= ~dp_phase;
      dp_left_o <= s_link & ~dark & dp_phase;
    end
  end

  // Checks.
  property p_dark;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      dark |-> ##2 (!run_lamp_o && !unit_fault_lamp_o && !host_fault_lamp_o);
  endproperty
  a_dark: assert property (p_dark) else $error("lamps lit while dark");

  property p_off;
    @(posedge sys_clk_i) disable iff (!nrst_i) l_sys |=> outputs_off_o;
  endproperty
  a_off: assert property (p_off) else $error("outputs not forced off");

  property p_h1;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (l_unum && !dark) |=> (seg_left_o == error_indicator_pkg::SEG_H &&
                             seg_right_o == error_indicator_pkg::SEG_1);
  endproperty
  a_h1: assert property (p_h1) else $error("H1 not shown");

  property p_host_lamp;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (host_err && !dark) [*2] |=> (host_fault_lamp_o && !unit_fault_lamp_o);
  endproperty
  a_host_lamp: assert property (p_host_lamp) else $error("host lamp wrong");

  property p_hb;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (l_init && !l_unum && !dark) |=> (seg_right_o == error_indicator_pkg::SEG_B);
  endproperty
  a_hb: assert property (p_hb) else $error("Hb not shown");

  property p_h7;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (l_unreg && !l_init && !l_unum && !dark) |=> (seg_right_o == error_indicator_pkg::SEG_7);
  endproperty
  a_h7: assert property (p_h7) else $error("H7 not shown");

  property p_y4;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (l_rev && !l_unreg && !l_init && !l_unum && !dark) |=>
        (seg_left_o == error_indicator_pkg::SEG_Y);
  endproperty
  a_y4: assert property (p_y4) else $error("Y4 not shown");

  property p_h3;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (l_pmem && !host_err && !dark) [*2] |=>
        (unit_fault_lamp_o && !host_fault_lamp_o && seg_right_o == error_indicator_pkg::SEG_3);
  endproperty
  a_h3: assert property (p_h3) else $error("H3 indication wrong");

  property p_sticky;
    @(posedge sys_clk_i) disable iff (!nrst_i) (l_pmem || s_pmem) |=> l_pmem;
  endproperty
  a_sticky: assert property (p_sticky) else $error("latch cleared");

  // One phase step out of the marker and one out of the code, while nodes are affected.
  sequence s_mark_step;
    (show_state == SHOW_MARK) && phase_tick && any_al;
  endsequence
  sequence s_code_step;
    (show_state == SHOW_CODE) && phase_tick && any_al;
  endsequence
  property p_order;
    @(posedge sys_clk_i) disable iff (!nrst_i) s_mark_step |=> (show_state == SHOW_CODE);
  endproperty
  a_order: assert property (p_order) else $error("display order wrong");

  property p_code_node;
    @(posedge sys_clk_i) disable iff (!nrst_i) s_code_step |=> (show_state == SHOW_NODE);
  endproperty
  a_code_node: assert property (p_code_node) else $error("node not after code");

  property p_dp;
    @(posedge sys_clk_i) disable iff (!nrst_i) (!s_link) |=> !dp_left_o;
  endproperty
  a_dp: assert property (p_dp) else $error("dot lit with link off");

endmodule

// ==== tb_error_indicator_encoder.sv ====
`timescale 1ns/1ps
module tb_error_indicator_encoder;
  localparam int unsigned PH = 8;
  localparam int unsigned TK = 2;
  localparam int unsigned NC = 16;
  logic sys_clk_i, nrst_i, host_power_fail_i, system_fault_i, unit_number_bad_i;
  logic host_init_fail_i, unit_not_registered_i, sync_control_req_i;
  logic program_memory_fault_i, sync_link_enable_i;
  logic [7:0] host_revision_i;
  logic [NC-1:0] slave_al_error_i;
  logic [2:0] run_pattern_i;
  logic run_lamp_o, unit_fault_lamp_o, host_fault_lamp_o, dp_left_o, outputs_off_o;
  logic [6:0] seg_left_o, seg_right_o;
  logic [13:0] seq [8];
  int error_cnt;
  int checks;
  int hi;
  int a;
  int b;
  int k;

  error_indicator_encoder #(.NODE_COUNT(NC), .PHASE_CYCLES(PH), .TICK_CYCLES(TK)) DUT (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .host_power_fail_i(host_power_fail_i),
    .system_fault_i(system_fault_i), .unit_number_bad_i(unit_number_bad_i),
    .host_init_fail_i(host_init_fail_i), .unit_not_registered_i(unit_not_registered_i),
    .host_revision_i(host_revision_i), .sync_control_req_i(sync_control_req_i),
    .program_memory_fault_i(program_memory_fault_i), .slave_al_error_i(slave_al_error_i),
    .sync_link_enable_i(sync_link_enable_i), .run_pattern_i(run_pattern_i),
    .run_lamp_o(run_lamp_o), .unit_fault_lamp_o(unit_fault_lamp_o),
    .host_fault_lamp_o(host_fault_lamp_o), .seg_left_o(seg_left_o),
    .seg_right_o(seg_right_o), .dp_left_o(dp_left_o), .outputs_off_o(outputs_off_o));

  // Free-running system clock at 125 MHz.
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // Expected display pair for an error code index, worked out from the code table.
  function automatic logic [13:0] code_pair(input int c);
    case (c)
      0: return {error_indicator_pkg::SEG_H, error_indicator_pkg::SEG_1};
      1: return {error_indicator_pkg::SEG_H, error_indicator_pkg::SEG_B};
      2: return {error_indicator_pkg::SEG_H, error_indicator_pkg::SEG_7};
      3: return {error_indicator_pkg::SEG_Y, error_indicator_pkg::SEG_4};
      4: return {error_indicator_pkg::SEG_H, error_indicator_pkg::SEG_3};
      5: return {error_indicator_pkg::SEG_E, error_indicator_pkg::SEG_R};
      6: return {error_indicator_pkg::SEG_D, error_indicator_pkg::SEG_D};
      default: return {error_indicator_pkg::SEG_BLANK, error_indicator_pkg::SEG_BLANK};
    endcase
  endfunction

  // Node shown as two hex digits, high nibble on the left.
  function automatic logic [13:0] node_pair(input int n);
    return {error_indicator_pkg::HEX_SEG[n / 16], error_indicator_pkg::HEX_SEG[n % 16]};
  endfunction

  // Returns every input to its quiet value, normal run lamp steadily on.
  task automatic clear_in();
    host_power_fail_i = 1'b0;
    system_fault_i = 1'b0;
    unit_number_bad_i = 1'b0;
    host_init_fail_i = 1'b0;
    unit_not_registered_i = 1'b0;
    host_revision_i = 8'h13;
    sync_control_req_i = 1'b0;
    program_memory_fault_i = 1'b0;
    slave_al_error_i = '0;
    sync_link_enable_i = 1'b0;
    run_pattern_i = error_indicator_pkg::PAT_ON;
  endtask

  // Holds reset for five cycles and checks that every output is low meanwhile.
  task automatic do_reset();
    @(negedge sys_clk_i);
    clear_in();
    nrst_i = 1'b0;
    wait_cyc(5);
    lamps(3'b000, "reset lamps");
    codes(code_pair(7), "reset display");
    check(18'({dp_left_o, outputs_off_o}), 18'h0, "reset flags");
    nrst_i = 1'b1;
    wait_cyc(8);
  endtask

  // Counts the cycles out of 64 in which the run lamp or the decimal point is lit.
  task automatic count_hi(input bit dp);
    hi = 0;
    repeat (64)
    begin
      @(negedge sys_clk_i);
      hi += ((dp ? dp_left_o : run_lamp_o) === 1'b1);
    end
  endtask

  // Compares the three lamps, run first, with an expected set.
  task automatic lamps(input logic [2:0] exp, input string what);
    check(18'({run_lamp_o, unit_fault_lamp_o, host_fault_lamp_o}), 18'(exp), what);
  endtask

  // Compares both display digits, left first, with an expected pair.
  task automatic codes(input logic [13:0] exp, input string what);
    check(18'({seg_left_o, seg_right_o}), 18'(exp), what);
  endtask

  // Watchdog well beyond the expected fewer than a thousand cycles of the run.
  initial
  begin
    repeat (30000) @(posedge sys_clk_i);
    error_cnt++;
    print_verdict();
  end

  // Main sequence.
  initial
  begin
    error_cnt = 0;
    checks = 0;
    nrst_i = 1'b0;
    clear_in();
    void'($urandom(32'hC2272784));
    do_reset();
    // Every lamp pattern: steady ones hold, the others toggle.
    for (int p = 0; p < 6; p++)
    begin
      run_pattern_i = 3'(p);
      wait_cyc(8);
      count_hi(1'b0);
      if (p == error_indicator_pkg::PAT_ON)
        check(18'(hi), 18'd64, "pattern on");
      else if (p == error_indicator_pkg::PAT_OFF)
        check(18'(hi), 18'd0, "pattern off");
      else
        check(18'(hi > 0 && hi < 64), 18'd1, "pattern toggles");
    end
    // Decimal point flashes only while the data link is enabled.
    sync_link_enable_i = 1'b1;
    wait_cyc(8);
    count_hi(1'b1);
    check(18'(hi > 0 && hi < 64), 18'd1, "dp flashes");
    sync_link_enable_i = 1'b0;
    wait_cyc(8);
    count_hi(1'b1);
    check(18'(hi), 18'd0, "dp idle");
    // Revision exactly at the minimum must not raise the revision error.
    sync_control_req_i = 1'b1;
    wait_cyc(8);
    check(18'(host_fault_lamp_o), 18'd0, "rev ok");
    // Each latched host or unit error, then released to show it persists.
    for (int c = 0; c < 5; c++)
    begin
      do_reset();
      case (c)
        0: unit_number_bad_i = 1'b1;
        1: host_init_fail_i = 1'b1;
        2: unit_not_registered_i = 1'b1;
        3:
        begin
          host_revision_i = ($urandom % 2) ? {4'h1, 4'($urandom % 3)} : {4'h0, 4'($urandom)};
          sync_control_req_i = 1'b1;
        end
        default: program_memory_fault_i = 1'b1;
      endcase
      for (int r = 0; r < 2; r++)
      begin
        wait_cyc(8);
        lamps((c == 4) ? 3'b010 : 3'b001, "lamps");
        codes(code_pair(c), "code");
        clear_in();
      end
    end
    // Two node errors cycle as marker, code, node, starting from the lowest node.
    do_reset();
    a = $urandom % 15;
    b = a + 1 + ($urandom % (15 - a));
    slave_al_error_i[a] = 1'b1;
    slave_al_error_i[b] = 1'b1;
    k = 0;
    while (k < 100 && {seg_left_o, seg_right_o} !== code_pair(5))
    begin
      wait_cyc(1);
      k++;
    end
    check(18'(k < 100), 18'd1, "marker seen");
    while (k < 200 && {seg_left_o, seg_right_o} === code_pair(5))
    begin
      wait_cyc(1);
      k++;
    end
    wait_cyc(PH / 2);
    seq = '{code_pair(6), node_pair(a), code_pair(5), code_pair(6), node_pair(b),
            code_pair(5), code_pair(6), node_pair(a)};
    for (int i = 0; i < 8; i++)
    begin
      codes(seq[i], "node sequence");
      wait_cyc(PH);
    end
    // Host error outranks the node sequence, and a system fault darkens all.
    unit_number_bad_i = 1'b1;
    host_init_fail_i = 1'b1;
    wait_cyc(8);
    codes(code_pair(0), "priority");
    system_fault_i = 1'b1;
    wait_cyc(8);
    lamps(3'b000, "fault lamps");
    codes(code_pair(7), "fault dark");
    check(18'(outputs_off_o), 18'd1, "outputs off");
    do_reset();
    host_power_fail_i = 1'b1;
    program_memory_fault_i = 1'b1;
    wait_cyc(10);
    lamps(3'b000, "supply loss lamps");
    codes(code_pair(7), "supply loss display");
    print_verdict();
  end
endmodule
